//--- rtl/awu_pkg.sv
// Overview of operation
// - halt with enable bit set enters timed wake halt on the rc clock
// - rc clock goes through fixed divide by 64, then the prescaler
// - sleep lasts 64 x prescaler rc periods plus rc start-up time
// - on expiry set flag, raise wake interrupt, start osc, wait 256 cycles
// - after stabilisation the cpu resumes with the wake interrupt vector
// - reading control/status clears the wake flag and its pending request
// - wake flag is bit 2, writes never change it, reads 1 after wake
// - measurement bit 1 in run enables rc osc and routes it to capture
// - enable bit 0 is read/write; when clear, halt has no timed wake
// - reset gives control/status 00h and prescaler FFh
// - prescaler value is the division factor, 01h to FFh; 00h illegal
// - a write of 00h to the prescaler is ignored
// - halt entry forces the interrupt mask clear; pending irq wakes at once
// - reset or any halt-exit interrupt also leaves timed wake halt
// - in timed wake halt the main osc is off and peripherals stop
// - watchdog reset on halt depends on the watchdog-in-halt option
package awu_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam int          ADDR_W    = 12;
    localparam logic [7:0]  CSR_IDX   = 8'h48;
    localparam logic [7:0]  PR_IDX    = 8'h49;
    localparam logic [7:0]  IST_IDX   = 8'h4A;
    localparam logic [7:0]  IMSK_IDX  = 8'h4B;
    localparam logic [11:0] CSR_ADDR  = {2'h0, CSR_IDX, 2'h0};
    localparam logic [11:0] PR_ADDR   = {2'h0, PR_IDX, 2'h0};
    localparam logic [11:0] IST_ADDR  = {2'h0, IST_IDX, 2'h0};
    localparam logic [11:0] IMSK_ADDR = {2'h0, IMSK_IDX, 2'h0};

    // ----------------------------------------------------------------
    // fields and reset values
    // ----------------------------------------------------------------
    localparam int         EN_BIT     = 0;
    localparam int         MEAS_BIT   = 1;
    localparam int         FLAG_BIT   = 2;
    localparam int         EV_WAKE    = 0;
    localparam int         EV_RESUME  = 1;
    localparam logic [7:0] CSR_RST    = 8'h00;
    localparam logic [7:0] PR_RST     = 8'hFF;
    localparam logic [7:0] PR_ILLEGAL = 8'h00;
    localparam logic [1:0] IRQ_RST    = 2'h0;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int         FIX_DIV     = 64;
    localparam logic [5:0] DIV_MAX     = 6'(FIX_DIV - 1);
    localparam int         CNT_W       = 10;
    localparam int         STAB_CYC    = 256;
    localparam int         CLK_NS      = 25;
    localparam int         RC_STRT_NS  = 1000;
    localparam int         RC_STRT_CYC = (RC_STRT_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [9:0] STAB_LAST   = 10'(STAB_CYC - 1);
    localparam logic [9:0] STRT_LAST   = 10'(RC_STRT_CYC - 1);

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [4:0] {
        ST_RUN    = 5'b00001,
        ST_HALT   = 5'b00010,
        ST_RCSTRT = 5'b00100,
        ST_SLEEP  = 5'b01000,
        ST_STAB   = 5'b10000
    } state_t;

    typedef struct packed {
        logic main_osc_on;
        logic rc_osc_en;
        logic periph_stop;
        logic mask_clr;
    } pwr_t;

endpackage

//--- rtl/awu_timer.sv
// Implementation choice: register access over APB.
`timescale 1ns/100ps
`default_nettype none
module awu_timer (
    // clock and reset
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    // apb slave
    input  wire logic [11:0]          paddr,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [31:0]          pwdata,
    input  wire logic [3:0]           pstrb,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    // cpu side
    input  wire logic                 halt_req,
    input  wire logic                 exit_irq,
    input  wire logic                 wdg_active,
    input  wire logic                 watchdog_in_halt_option,
    // rc oscillator pin
    input  wire logic                 rc_clk_pin,
    // power and wake outputs
    output awu_pkg::pwr_t             pwr,
    output logic                      capture_rc,
    output logic                      wake_irq_req,
    output logic                      resume_pulse,
    output logic                      resume_awu,
    output logic                      wdg_reset_req,
    output logic                      irq
);
    import awu_pkg::*;

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic [1:0]  rc_sync_ff;
    logic        rc_q_ff;
    logic        rc_tick;
    logic [31:0] prdata_ff;
    logic        pready_ff;
    logic        pslverr_ff;
    logic        setup;
    logic        done;
    logic        wr_ok;
    logic        rd_csr;
    logic        hit;
    logic        en_ff;
    logic        meas_ff;
    logic        flag_ff;
    logic [7:0]  pr_ff;
    logic [1:0]  ist_ff;
    logic [1:0]  imsk_ff;
    logic        irq_ff;
    state_t      state_ff;
    state_t      nxt_state;
    logic [9:0]  cnt_ff;
    logic [5:0]  div_ff;
    logic [7:0]  ps_ff;
    logic        expire;
    logic        wdg_hit;
    logic        enter;
    logic        woke_awu_ff;
    pwr_t        pwr_ff;
    logic        capture_ff;
    logic        resume_ff;
    logic        resume_awu_ff;
    logic        wdg_rst_ff;
    logic        halted;

    // ----------------------------------------------------------------
    // rc pin synchroniser
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rc_sync_ff <= 2'h0;
            rc_q_ff    <= 1'b0;
        end else begin
            rc_sync_ff <= {rc_sync_ff[0], rc_clk_pin};
            rc_q_ff    <= rc_sync_ff[1];
        end
    end

    assign rc_tick = rc_sync_ff[1] & ~rc_q_ff;

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    assign setup  = psel & ~penable;
    assign done   = psel & penable & pready_ff;
    assign wr_ok  = done & pwrite & ~pslverr_ff;
    assign rd_csr = done & ~pwrite & (paddr == CSR_ADDR);
    assign hit    = (paddr == CSR_ADDR) | (paddr == PR_ADDR) |
                    (paddr == IST_ADDR) | (paddr == IMSK_ADDR);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0;
        end else begin
            pready_ff  <= setup;
            pslverr_ff <= setup & ~hit;
            if (setup) begin
                prdata_ff <= 32'h0;
                case (paddr)
                    CSR_ADDR: begin
                        prdata_ff[EN_BIT]   <= en_ff;
                        prdata_ff[MEAS_BIT] <= meas_ff;
                        prdata_ff[FLAG_BIT] <= flag_ff;
                    end
                    PR_ADDR:   prdata_ff[7:0] <= pr_ff;
                    IST_ADDR:  prdata_ff[1:0] <= ist_ff;
                    IMSK_ADDR: prdata_ff[1:0] <= imsk_ff;
                    default:   prdata_ff <= 32'h0;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // software registers
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_ff   <= CSR_RST[EN_BIT];
            meas_ff <= CSR_RST[MEAS_BIT];
        end else if (wr_ok & pstrb[0] & (paddr == CSR_ADDR)) begin
            en_ff   <= pwdata[EN_BIT];
            meas_ff <= pwdata[MEAS_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pr_ff <= PR_RST;
        end else if (wr_ok & pstrb[0] & (paddr == PR_ADDR) &
                     (pwdata[7:0] != PR_ILLEGAL)) begin
            pr_ff <= pwdata[7:0];
        end
    end

    // set wins over the read clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_ff <= CSR_RST[FLAG_BIT];
        end else begin
            flag_ff <= expire |
                       (flag_ff & ~(rd_csr & prdata_ff[FLAG_BIT]));
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ist_ff  <= IRQ_RST;
            imsk_ff <= IRQ_RST;
            irq_ff  <= 1'b0;
        end else begin
            ist_ff[EV_WAKE]   <= expire | (ist_ff[EV_WAKE] &
                ~(wr_ok & pstrb[0] & (paddr == IST_ADDR) &
                  pwdata[EV_WAKE]));
            ist_ff[EV_RESUME] <= resume_ff | (ist_ff[EV_RESUME] &
                ~(wr_ok & pstrb[0] & (paddr == IST_ADDR) &
                  pwdata[EV_RESUME]));
            if (wr_ok & pstrb[0] & (paddr == IMSK_ADDR)) begin
                imsk_ff <= pwdata[1:0];
            end
            irq_ff <= |(ist_ff & imsk_ff);
        end
    end

    // ----------------------------------------------------------------
    // halt control
    // ----------------------------------------------------------------
    assign wdg_hit = wdg_active & ~watchdog_in_halt_option;
    assign enter   = (state_ff == ST_RUN) & halt_req & ~wdg_hit;
    assign halted  = (nxt_state == ST_HALT) | (nxt_state == ST_RCSTRT) |
                     (nxt_state == ST_SLEEP);

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_RUN: begin
                if (enter & exit_irq) begin
                    nxt_state = ST_STAB;
                end else if (enter & en_ff) begin
                    nxt_state = ST_RCSTRT;
                end else if (enter) begin
                    nxt_state = ST_HALT;
                end
            end
            ST_HALT: begin
                if (exit_irq) begin
                    nxt_state = ST_STAB;
                end
            end
            ST_RCSTRT: begin
                if (exit_irq) begin
                    nxt_state = ST_STAB;
                end else if (cnt_ff == STRT_LAST) begin
                    nxt_state = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (exit_irq | expire) begin
                    nxt_state = ST_STAB;
                end
            end
            ST_STAB: begin
                if (cnt_ff == STAB_LAST) begin
                    nxt_state = ST_RUN;
                end
            end
            default: nxt_state = ST_RUN;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= ST_RUN;
            cnt_ff   <= 10'h0;
        end else begin
            state_ff <= nxt_state;
            if (nxt_state != state_ff) begin
                cnt_ff <= 10'h0;
            end else begin
                cnt_ff <= 10'(cnt_ff + 10'h1);
            end
        end
    end

    // ----------------------------------------------------------------
    // wake divider chain
    // ----------------------------------------------------------------
    assign expire = (state_ff == ST_SLEEP) & rc_tick &
                    (div_ff == DIV_MAX) &
                    (ps_ff == 8'(pr_ff - 8'h01));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_ff <= 6'h0;
            ps_ff  <= 8'h0;
        end else if (nxt_state != ST_SLEEP) begin
            div_ff <= 6'h0;
            ps_ff  <= 8'h0;
        end else if (rc_tick) begin
            div_ff <= 6'(div_ff + 6'h1);
            if (div_ff == DIV_MAX) begin
                ps_ff <= 8'(ps_ff + 8'h01);
            end
        end
    end

    // ----------------------------------------------------------------
    // power and wake outputs
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwr_ff        <= '{1'b1, 1'b0, 1'b0, 1'b0};
            capture_ff    <= 1'b0;
            resume_ff     <= 1'b0;
            resume_awu_ff <= 1'b0;
            woke_awu_ff   <= 1'b0;
            wdg_rst_ff    <= 1'b0;
        end else begin
            pwr_ff.main_osc_on <= ~halted;
            pwr_ff.periph_stop <= halted;
            pwr_ff.rc_osc_en   <= (nxt_state == ST_RCSTRT) |
                (nxt_state == ST_SLEEP) |
                ((nxt_state == ST_RUN) & meas_ff);
            pwr_ff.mask_clr    <= enter;
            capture_ff <= (state_ff == ST_RUN) & meas_ff &
                          rc_sync_ff[1];
            resume_ff  <= (state_ff == ST_STAB) &
                          (nxt_state == ST_RUN);
            if (resume_ff) begin
                resume_awu_ff <= 1'b0;
            end else if ((state_ff == ST_STAB) &
                         (nxt_state == ST_RUN)) begin
                resume_awu_ff <= woke_awu_ff;
            end
            if (enter) begin
                woke_awu_ff <= 1'b0;
            end else if (expire) begin
                woke_awu_ff <= 1'b1;
            end
            wdg_rst_ff <= (state_ff == ST_RUN) & halt_req & wdg_hit;
        end
    end

    assign prdata        = prdata_ff;
    assign pready        = pready_ff;
    assign pslverr       = pslverr_ff;
    assign pwr           = pwr_ff;
    assign capture_rc    = capture_ff;
    assign wake_irq_req  = flag_ff;
    assign resume_pulse  = resume_ff;
    assign resume_awu    = resume_awu_ff;
    assign wdg_reset_req = wdg_rst_ff;
    assign irq           = irq_ff;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_timed_entry: assert property (enter & ~exit_irq & en_ff |=>
        state_ff == ST_RCSTRT && pwr_ff.mask_clr && !pwr_ff.main_osc_on)
        else $error("timed halt not entered");
    a_plain_halt: assert property (enter & ~exit_irq & ~en_ff |=>
        state_ff == ST_HALT) else $error("plain halt wrong");
    a_pending_wake: assert property (enter & exit_irq |=>
        state_ff == ST_STAB && pwr_ff.mask_clr)
        else $error("pending irq no wake");
    a_rc_start_len: assert property (state_ff == ST_RCSTRT &&
        cnt_ff < STRT_LAST && !exit_irq |=> state_ff == ST_RCSTRT)
        else $error("rc start-up cut short");
    a_expire_flag: assert property (expire |=> flag_ff &&
        state_ff == ST_STAB && ist_ff[EV_WAKE])
        else $error("expiry not flagged");
    a_stab_hold: assert property (state_ff == ST_STAB &&
        cnt_ff < STAB_LAST |=> state_ff == ST_STAB)
        else $error("stabilisation too short");
    a_stab_resume: assert property (state_ff == ST_STAB &&
        cnt_ff == STAB_LAST |=> state_ff == ST_RUN && resume_pulse)
        else $error("no resume after stab");
    a_read_clear: assert property (rd_csr && prdata_ff[FLAG_BIT] &&
        !expire |=> !flag_ff) else $error("read left flag");
    a_flag_write: assert property (wr_ok && paddr == CSR_ADDR &&
        !expire |=> flag_ff == $past(flag_ff))
        else $error("write changed flag");
    a_reserved_zero: assert property (setup && paddr == CSR_ADDR |=>
        prdata_ff[7:3] == 5'h0) else $error("reserved bits set");
    a_pr_zero_keep: assert property (wr_ok && paddr == PR_ADDR &&
        pwdata[7:0] == PR_ILLEGAL |=> pr_ff == $past(pr_ff))
        else $error("zero prescaler taken");
    a_exit_irq: assert property ((state_ff == ST_SLEEP ||
        state_ff == ST_HALT) && exit_irq |=> state_ff == ST_STAB)
        else $error("halt exit missed");
    a_osc_off: assert property (state_ff == ST_SLEEP &&
        $past(state_ff == ST_SLEEP) |-> !pwr_ff.main_osc_on &&
        pwr_ff.periph_stop && pwr_ff.rc_osc_en)
        else $error("osc on in sleep");
    a_wdg_reset: assert property (state_ff == ST_RUN && halt_req &&
        wdg_hit |=> wdg_reset_req && state_ff == ST_RUN)
        else $error("watchdog halt wrong");
    a_div_idle: assert property (state_ff != ST_SLEEP |->
        div_ff == 6'h0 && ps_ff == 8'h0)
        else $error("divider not cleared");

    c_timed_wake: cover property (expire ##[1:300] resume_pulse);
    c_plain_halt: cover property (state_ff == ST_HALT ##1
        state_ff == ST_STAB);
    c_measure: cover property (capture_rc);
    c_wdg: cover property (wdg_reset_req);

endmodule // awu_timer
`default_nettype wire

//--- bench/cpu_rc_model.sv
`timescale 1ns/100ps
`default_nettype none
module cpu_rc_model (
    // clock and reset
    input  wire logic           pclk,
    input  wire logic           presetn,
    // bench commands
    input  wire logic           halt_cmd,
    input  wire logic           irq_cmd,
    // device side
    input  wire awu_pkg::pwr_t  pwr,
    output logic                halt_req,
    output logic                exit_irq,
    output logic                rc_clk_pin
);
    import awu_pkg::*;

    logic cmd_ff;

    // ------------------------------------------------
    // cpu: halt instruction only while clocked
    // ------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_ff   <= 1'b0;
            halt_req <= 1'b0;
        end else begin
            cmd_ff   <= halt_cmd;
            halt_req <= halt_cmd & ~cmd_ff & pwr.main_osc_on;
        end
    end

    assign exit_irq = irq_cmd;

    // ------------------------------------------------
    // rc oscillator, still while disabled
    // ------------------------------------------------
    initial begin
        rc_clk_pin = 1'b0;
        forever begin
            #53;
            rc_clk_pin = pwr.rc_osc_en ? ~rc_clk_pin : 1'b0;
        end
    end
endmodule // cpu_rc_model
`default_nettype wire

//--- bench/test_awu_timer.sv
`timescale 1ns/100ps
`default_nettype none
module test_awu_timer;
    import awu_pkg::*;

    logic        pclk, presetn, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb;
    logic        pready, pslverr, er, halt_req, exit_irq, rc_clk_pin;
    logic        wdg_active, watchdog_in_halt_option, halt_cmd, irq_cmd;
    logic        capture_rc, wake_irq_req, resume_pulse, resume_awu;
    logic        wdg_reset_req, irq;
    pwr_t        pwr;
    int          num_errors, cmp_count, seed, n, e, pr_m;
    bit          en_m, meas_m, flag_m;

    awu_timer u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .halt_req(halt_req), .exit_irq(exit_irq),
        .wdg_active(wdg_active),
        .watchdog_in_halt_option(watchdog_in_halt_option),
        .rc_clk_pin(rc_clk_pin), .pwr(pwr), .capture_rc(capture_rc),
        .wake_irq_req(wake_irq_req), .resume_pulse(resume_pulse),
        .resume_awu(resume_awu), .wdg_reset_req(wdg_reset_req),
        .irq(irq));

    cpu_rc_model u_cpu (.pclk(pclk), .presetn(presetn),
        .halt_cmd(halt_cmd), .irq_cmd(irq_cmd), .pwr(pwr),
        .halt_req(halt_req), .exit_irq(exit_irq),
        .rc_clk_pin(rc_clk_pin));

    // ------------------------------------------------
    // compare and bus tasks
    // ------------------------------------------------
    task automatic chk(input string s, input logic [31:0] x,
                       input logic [31:0] g);
        cmp_count++;
        if (g !== x) begin
            num_errors++;
            $display("Error %s expected %h seen %h", s, x, g);
        end
    endtask

    task automatic chk_rng(input string s, input int lo, input int hi,
                           input int g);
        cmp_count++;
        if (g < lo || g > hi) begin
            num_errors++;
            $display("Error %s expected %0d..%0d seen %0d", s, lo, hi, g);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [7:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr_csr(input logic [7:0] d);
        apb(1'b1, CSR_ADDR, d);
        en_m   = d[0];
        meas_m = d[1];
    endtask

    task automatic rd_csr();
        apb(1'b0, CSR_ADDR, 8'h00);
        chk("csr", {29'h0, flag_m, meas_m, en_m}, rd);
        flag_m = 0;
    endtask

    task automatic wr_pr(input logic [7:0] d);
        apb(1'b1, PR_ADDR, d);
        if (d != 8'h00) pr_m = d;
    endtask

    task automatic rd_pr();
        apb(1'b0, PR_ADDR, 8'h00);
        chk("prescaler", pr_m, rd);
    endtask

    task automatic do_halt();
        @(posedge pclk);
        halt_cmd <= 1'b1;
        @(posedge pclk);
        halt_cmd <= 1'b0;
    endtask

    task automatic set_irq(input logic v);
        @(posedge pclk);
        irq_cmd <= v;
    endtask

    function automatic logic sig(input int k);
        case (k)
            0: return wake_irq_req;
            1: return resume_pulse;
            2: return pwr.mask_clr;
            3: return wdg_reset_req;
            default: return capture_rc;
        endcase
    endfunction

    task automatic wait_sig(input int k, input int lim);
        n = 0;
        while (sig(k) !== 1'b1 && n < lim) begin
            @(posedge pclk);
            n++;
        end
    endtask

    task automatic print_verdict();
        if (num_errors == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ------------------------------------------------
    // clock, watchdog, main sequence
    // ------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    initial begin
        #(20000 * 25);
        num_errors++;
        print_verdict();
    end

    initial begin
        seed = 32'ha8d4ef52;
        {presetn, psel, penable, pwrite, halt_cmd, irq_cmd} = '0;
        {wdg_active, watchdog_in_halt_option} = '0;
        paddr = '0;
        pwdata = '0;
        pstrb = 4'hF;
        pr_m = 255;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rd_csr();
        rd_pr();
        apb(1'b0, 12'h200, 8'h00);
        chk("unmapped error", 1, er);
        chk("unmapped data", 0, rd);
        wr_csr(8'hFC);
        rd_csr();
        wr_pr(8'h00);
        rd_pr();
        wr_csr(8'h02);
        wait_sig(4, 40);
        chk_rng("rc capture", 0, 39, n);
        chk("rc osc enable", 1, pwr.rc_osc_en);
        wr_csr(8'h00);
        do_halt();
        wait_sig(2, 8);
        chk_rng("mask clear", 0, 7, n);
        chk("osc off", 0, pwr.main_osc_on);
        chk("periph stop", 1, pwr.periph_stop);
        chk("capture stopped", 0, capture_rc);
        repeat (600) @(posedge pclk);
        chk("no timed wake", 0, wake_irq_req);
        set_irq(1'b1);
        wait_sig(1, 300);
        chk_rng("irq exit", 254, 264, n);
        chk("resume source", 0, resume_awu);
        set_irq(1'b0);
        set_irq(1'b1);
        do_halt();
        wait_sig(1, 300);
        chk_rng("pending wake", 250, 265, n);
        set_irq(1'b0);
        wdg_active <= 1'b1;
        do_halt();
        wait_sig(3, 8);
        chk_rng("wdg reset", 0, 7, n);
        chk("osc kept", 1, pwr.main_osc_on);
        watchdog_in_halt_option <= 1'b1;
        do_halt();
        wait_sig(2, 8);
        chk_rng("halt with wdg", 0, 7, n);
        set_irq(1'b1);
        wait_sig(1, 300);
        chk_rng("wdg halt exit", 254, 264, n);
        set_irq(1'b0);
        wdg_active <= 1'b0;
        wr_csr(8'h01);
        do_halt();
        repeat (300) @(posedge pclk);
        set_irq(1'b1);
        wait_sig(1, 300);
        chk_rng("cut sleep exit", 254, 264, n);
        chk("cut sleep source", 0, resume_awu);
        set_irq(1'b0);
        rd_csr();
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, IMSK_ADDR, (i == 0) ? 8'h01 : 8'h00);
            wr_pr((i == 0) ? 8'h01 : 8'(1 + {$random(seed)} % 3));
            do_halt();
            wait_sig(0, 3000);
            e = 41 + 64 * pr_m * 106 / 25;
            chk_rng("sleep time", e - 8, e + 14, n);
            chk("osc restart", 1, pwr.main_osc_on);
            flag_m = 1;
            wait_sig(1, 300);
            chk_rng("stabilise", 254, 260, n);
            chk("resume source", 1, resume_awu);
            chk("irq line", (i == 0), irq);
            apb(1'b0, IST_ADDR, 8'h00);
            chk("status", 3, rd);
            rd_csr();
            rd_csr();
            chk("wake request", 0, wake_irq_req);
            apb(1'b1, IST_ADDR, 8'h03);
            apb(1'b0, IST_ADDR, 8'h00);
            chk("status clear", 0, rd);
            chk("irq cleared", 0, irq);
        end
        print_verdict();
    end
endmodule // test_awu_timer
`default_nettype wire
